/* rtl/analog_shared_gpio_port.sv */
// module: eight-bit port shared with analog converter inputs
`timescale 1ns/100ps
module analog_shared_gpio_port
  import gpio_port_pkg::*;
#(
  parameter int W = PORT_WIDTH
) (
  // clock and reset
  input  wire logic                  MCLK_I,
  input  wire logic                  RESETN_I,
  // register port
  input  wire logic [ADDR_WIDTH-1:0] ADDR_I,
  input  wire logic [7:0]            WDATA_I,
  input  wire logic                  WR_I,
  input  wire logic                  RD_I,
  output logic      [7:0]            RDATA_O,
  // pins
  input  wire logic [W-1:0]          PIN_I,
  output logic      [W-1:0]          PIN_O,
  output logic      [W-1:0]          PIN_OE_O,
  output logic      [W-1:0]          PIN_REDUCED_DRIVE_O,
  output logic      [W-1:0]          PULL_UP_EN_O,
  output logic      [W-1:0]          PULL_DOWN_EN_O,
  // peripheral and analog converter sharing
  input  wire logic [W-1:0]          ANALOG_CH_EN_I,
  input  wire logic [W-1:0]          PERIPH_CTRL_I,
  input  wire logic [W-1:0]          PERIPH_OUT_I,
  input  wire logic [W-1:0]          PERIPH_OE_I
);

  // ==========================================================
  // register storage
  logic [W-1:0] out_data_q;
  logic [W-1:0] dir_q;
  logic [W-1:0] drive_q;
  logic [W-1:0] pull_en_q;
  logic [W-1:0] pull_pol_q;
  logic [7:0]   rdata_q;
  logic [7:0]   rdata_d;
  logic [W-1:0] pin_level;
  reg_sel_t     wsel;
  reg_sel_t     rsel;

  assign wsel = WR_I ? decode_addr(ADDR_I) : SEL_NONE;
  assign rsel = decode_addr(ADDR_I);

  // ==========================================================
  // pin synchroniser
  pin_sync_if #(.W(W)) pins ();

  assign pins.raw  = PIN_I;
  assign pin_level = pins.synced;

  pin_sync #(
    .W       (W)
  ) u_sync (
    .clk_i   (MCLK_I),
    .rst_n_i (RESETN_I),
    .pins    (pins)
  );

  // ==========================================================
  // writable registers; a write to the pin input offset or to an
  // unmapped offset falls through and changes nothing [R2]
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      out_data_q <= RST_OUT_DATA[W-1:0]; // [R14]
    end else if (wsel == SEL_OUT_DATA) begin
      out_data_q <= WDATA_I[W-1:0];      // [R14]
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dir_q <= RST_DIR[W-1:0];           // [R14]
    end else if (wsel == SEL_DIR) begin
      dir_q <= WDATA_I[W-1:0];
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      drive_q <= RST_DRIVE[W-1:0];       // [R14]
    end else if (wsel == SEL_DRIVE) begin
      drive_q <= WDATA_I[W-1:0];
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pull_en_q <= RST_PULL_EN[W-1:0];   // [R9]
    end else if (wsel == SEL_PULL_EN) begin
      pull_en_q <= WDATA_I[W-1:0];
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pull_pol_q <= RST_PULL_POL[W-1:0]; // [R14]
    end else if (wsel == SEL_PULL_POL) begin
      pull_pol_q <= WDATA_I[W-1:0];
    end
  end

  // ==========================================================
  // read path, data stand one cycle after the strobe only
  always_comb begin
    rdata_d = RST_UNMAPPED;
    case (rsel)
      SEL_OUT_DATA: rdata_d[W-1:0] = (dir_q & out_data_q) |
                                     (~dir_q & pin_level);   // [R1]
      SEL_PIN_IN:   rdata_d[W-1:0] = pin_level;              // [R3]
      SEL_DIR:      rdata_d[W-1:0] = dir_q;
      SEL_DRIVE:    rdata_d[W-1:0] = drive_q;
      SEL_PULL_EN:  rdata_d[W-1:0] = pull_en_q;
      SEL_PULL_POL: rdata_d[W-1:0] = pull_pol_q;
      default:      rdata_d        = RST_UNMAPPED;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_q <= RST_UNMAPPED;
    end else if (RD_I) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= RST_UNMAPPED;
    end
  end

  assign RDATA_O = rdata_q;

  // ==========================================================
  // pad control, per pin
  // a peripheral that owns a pin decides its direction and value;
  // the pull and drive settings still follow the resulting direction
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_pad
      logic is_out;
      logic pull_on;
      assign is_out = PERIPH_CTRL_I[g] ? PERIPH_OE_I[g]   // [R13]
                                       : dir_q[g];        // [R4]
      assign PIN_OE_O[g] = is_out;                        // [R4]
      // latch reaches the pad only as general purpose output
      assign PIN_O[g] = PERIPH_CTRL_I[g] ? PERIPH_OUT_I[g]
                      : (dir_q[g] & out_data_q[g]);       // [R12]
      // reduced drive has no meaning on an undriven pad
      assign PIN_REDUCED_DRIVE_O[g] = is_out & drive_q[g]; // [R6] [R7]
      // analog channel always wins so the pull never loads the input
      assign pull_on = pull_en_q[g] & ~is_out             // [R8]
                     & ~ANALOG_CH_EN_I[g];                // [R10]
      assign PULL_UP_EN_O[g]   = pull_on & ~pull_pol_q[g]; // [R11]
      assign PULL_DOWN_EN_O[g] = pull_on &  pull_pol_q[g]; // [R11]
    end
  endgenerate

endmodule

/* rtl/gpio_port_pkg.sv */
// package: register map, field widths and reset values of the port block
//
// Contract
// [R1] a read of the output data register returns the latch where the direction bit is 1 and the synchronised pin where it is 0.
// [R2] the pin input register is read-only and a write to it changes no state.
// [R3] a read of the pin input register returns the synchronised level of every pin regardless of direction.
// [R4] a direction bit of 0 makes its pin an input and 1 makes it a driven output.
// [R5] pin sampling passes a two-stage synchroniser, so reads may lag a direction change by up to two bus cycles.
// [R6] a drive strength bit of 0 gives full drive and 1 gives reduced drive on its output pin.
// [R7] the drive strength bit is disregarded while its pin is an input.
// [R8] a pull enable bit of 1 enables a pull only while its pin is an input.
// [R9] after reset every pull enable bit is cleared.
// [R10] a pull is forced off while the matching analog converter channel is enabled.
// [R11] a polarity bit of 0 selects a pull-up and 1 a pull-down for an enabled pull.
// [R12] the output data value reaches a pin only while that pin is a general purpose output.
// [R13] a pin taken over by a peripheral ignores its direction bit.
// [R14] all writable registers are readable and writable at any time and reset to zero.
package gpio_port_pkg;

  // ==========================================================
  // widths
  localparam int          PORT_WIDTH   = 8;
  localparam int          ADDR_WIDTH   = 8;
  localparam int          SYNC_STAGES  = 2;

  // ==========================================================
  // register offsets
  localparam logic [7:0]  OFS_OUT_DATA = 8'h30;
  localparam logic [7:0]  OFS_PIN_IN   = 8'h31;
  localparam logic [7:0]  OFS_DIR      = 8'h32;
  localparam logic [7:0]  OFS_DRIVE    = 8'h33;
  localparam logic [7:0]  OFS_PULL_EN  = 8'h34;
  localparam logic [7:0]  OFS_PULL_POL = 8'h35;

  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_OUT_DATA = 8'h00;
  localparam logic [7:0]  RST_DIR      = 8'h00;
  localparam logic [7:0]  RST_DRIVE    = 8'h00;
  localparam logic [7:0]  RST_PULL_EN  = 8'h00;
  localparam logic [7:0]  RST_PULL_POL = 8'h00;
  localparam logic [7:0]  RST_UNMAPPED = 8'h00;

  // ==========================================================
  // register select
  typedef enum logic [2:0] {
    SEL_NONE     = 3'b000,
    SEL_OUT_DATA = 3'b001,
    SEL_PIN_IN   = 3'b010,
    SEL_DIR      = 3'b011,
    SEL_DRIVE    = 3'b100,
    SEL_PULL_EN  = 3'b101,
    SEL_PULL_POL = 3'b110
  } reg_sel_t;

  function automatic reg_sel_t decode_addr(input logic [7:0] addr);
    case (addr)
      OFS_OUT_DATA: decode_addr = SEL_OUT_DATA;
      OFS_PIN_IN:   decode_addr = SEL_PIN_IN;
      OFS_DIR:      decode_addr = SEL_DIR;
      OFS_DRIVE:    decode_addr = SEL_DRIVE;
      OFS_PULL_EN:  decode_addr = SEL_PULL_EN;
      OFS_PULL_POL: decode_addr = SEL_PULL_POL;
      default:      decode_addr = SEL_NONE;
    endcase
  endfunction

endpackage

/* rtl/pin_sync_if.sv */
// interface: raw pin levels in, synchronised pin levels out
`timescale 1ns/100ps
interface pin_sync_if #(
  parameter int W = 8
);
  logic [W-1:0] raw;
  logic [W-1:0] synced;

  modport sync (
    input  raw,
    output synced
  );
  modport user (
    output raw,
    input  synced
  );
endinterface

/* rtl/pin_sync.sv */
// module: per-pin two-flop synchroniser for the pad input levels
`timescale 1ns/100ps
module pin_sync
  import gpio_port_pkg::*;
#(
  parameter int W = PORT_WIDTH
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // pin levels
  pin_sync_if.sync  pins
);

  // ==========================================================
  // synchroniser, one pair of flops per pin
  // the first stage feeds only the second; nothing else reads it
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_q   <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q   <= pins.raw[g]; // [R5]
          stable_q <= meta_q;      // [R5]
        end
      end
      assign pins.synced[g] = stable_q;
    end
  endgenerate

endmodule

/* testbench/gpio_port_asserts.sv */
// checker: port-level assertions for the shared port block
`timescale 1ns/100ps
module gpio_port_asserts
  import gpio_port_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input wire logic                  MCLK_I,
  input wire logic                  RESETN_I,
  // register port
  input wire logic [ADDR_WIDTH-1:0] ADDR_I,
  input wire logic [7:0]            WDATA_I,
  input wire logic                  WR_I,
  input wire logic                  RD_I,
  input wire logic [7:0]            RDATA_O,
  // pins, analog channel enables and peripheral control
  input wire logic [W-1:0]          PIN_O,
  input wire logic [W-1:0]          PIN_OE_O,
  input wire logic [W-1:0]          PIN_REDUCED_DRIVE_O,
  input wire logic [W-1:0]          PULL_UP_EN_O,
  input wire logic [W-1:0]          PULL_DOWN_EN_O,
  input wire logic [W-1:0]          ANALOG_CH_EN_I,
  input wire logic [W-1:0]          PERIPH_CTRL_I,
  input wire logic [W-1:0]          PERIPH_OE_I
);
  // ==========================================================
  // shadow of the writable registers, seen from the bus
  logic [W-1:0] dir_q, out_q, drv_q, pe_q, pol_q;
  wire  [W-1:0] gp = ~PERIPH_CTRL_I;
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      {dir_q, out_q, drv_q, pe_q, pol_q} <= '0;
    end else if (WR_I) begin
      case (ADDR_I)
        OFS_OUT_DATA: out_q <= WDATA_I;
        OFS_DIR:      dir_q <= WDATA_I;
        OFS_DRIVE:    drv_q <= WDATA_I;
        OFS_PULL_EN:  pe_q <= WDATA_I;
        OFS_PULL_POL: pol_q <= WDATA_I;
        default:      ;
      endcase
    end
  end
  // ==========================================================
  // assertions
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data not idle");
  a_unmapped_rd: assert property (
    RD_I && decode_addr(ADDR_I) == SEL_NONE |=> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  a_dir_oe: assert property ((PIN_OE_O & gp) == (dir_q & gp))
    else $error("enable differs from direction");
  a_periph_oe: assert property (
    (PIN_OE_O & ~gp) == (PERIPH_OE_I & ~gp))
    else $error("owned pin ignores peripheral");
  a_out_value: assert property (
    (PIN_O & dir_q & gp) == (out_q & dir_q & gp))
    else $error("output latch not on pin");
  a_drive_mask: assert property (
    PIN_REDUCED_DRIVE_O == (drv_q & PIN_OE_O))
    else $error("drive strength wrong");
  a_pull_off: assert property (
    ((PULL_UP_EN_O | PULL_DOWN_EN_O) & (PIN_OE_O | ANALOG_CH_EN_I)) == '0)
    else $error("pull not off");
  a_pull_up: assert property (
    PULL_UP_EN_O == (pe_q & ~pol_q & ~PIN_OE_O & ~ANALOG_CH_EN_I))
    else $error("pull-up wrong");
  a_pull_down: assert property (
    PULL_DOWN_EN_O == (pe_q & pol_q & ~PIN_OE_O & ~ANALOG_CH_EN_I))
    else $error("pull-down wrong");
  c_pin_rd: cover property (RD_I && ADDR_I == OFS_PIN_IN);
  c_periph: cover property (|PERIPH_CTRL_I);
  c_pull_dn: cover property (|PULL_DOWN_EN_O);
endmodule
bind analog_shared_gpio_port gpio_port_asserts #(.W(W)) chk_inst (.*);

/* testbench/pad_model.sv */
// partner model: pads with an outside driver, pulls and floating level
`timescale 1ns/100ps
module pad_model (
  // clock
  input  wire logic       clk_i,
  // device side
  input  wire logic [7:0] dev_out_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pu_i,
  input  wire logic [7:0] pd_i,
  // outside driver, wins over the device to mimic a short
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] pad_o
);
  // an undriven pad with no pull toggles so a stale value never passes as read data
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge clk_i) float_q <= ~float_q;
  assign pad_o = ext_en_i & ext_i | ~ext_en_i & (oe_i & dev_out_i
    | ~oe_i & (pu_i | ~pd_i & float_q));
endmodule

/* testbench/tb_analog_shared_gpio_port.sv */
// testbench: register and pin scenarios for the shared port block
`timescale 1ns/100ps
module tb_analog_shared_gpio_port;
  import gpio_port_pkg::*;
  logic       clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [7:0] addr = 0, wdata = 0, an = 0, pc = 0, po = 0, poe = 0;
  logic [7:0] ext = 0, ext_en = 0, rdata, pin, pout, oe, drv, pu, pd, d;
  int         mismatches = 0, tests_run = 0;
  always #50 clk = ~clk;
  analog_shared_gpio_port analog_shared_gpio_port_inst (.MCLK_I(clk),
    .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .PIN_I(pin), .PIN_O(pout), .PIN_OE_O(oe),
    .PIN_REDUCED_DRIVE_O(drv), .PULL_UP_EN_O(pu), .PULL_DOWN_EN_O(pd),
    .ANALOG_CH_EN_I(an), .PERIPH_CTRL_I(pc), .PERIPH_OUT_I(po),
    .PERIPH_OE_I(poe));
  pad_model pad_model_inst (.clk_i(clk), .dev_out_i(pout), .oe_i(oe),
    .pu_i(pu), .pd_i(pd), .ext_i(ext), .ext_en_i(ext_en), .pad_o(pin));
  // ==========================================================
  // bus tasks and compare
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk) {wr, addr, wdata} <= {1'b1, a, v};
    @(posedge clk) wr <= 0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk) {rd, addr} <= {1'b1, a};
    @(posedge clk) rd <= 0;
    #1 v = rdata;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    for (int a = 8'h32; a <= 8'h35; a++) begin
      rd_reg(8'(a), d);
      cmp(d, 8'h00);
    end
    cmp(pu | pd | oe, 8'h00);
  endtask
  task automatic t_read_back;
    {ext, ext_en} <= {8'h3C, 8'hFF};
    wr_reg(OFS_OUT_DATA, 8'hA5);
    wr_reg(OFS_DIR, 8'hF0);
    cmp(oe, 8'hF0);
    cmp(pout & 8'hF0, 8'hA0);
    rd_reg(OFS_OUT_DATA, d);
    cmp(d, 8'hAC);
    rd_reg(OFS_PIN_IN, d);
    cmp(d, 8'h3C);
    ext <= 8'hC3;
    wr_reg(OFS_DIR, 8'h0F);
    @(posedge clk);
    rd_reg(OFS_OUT_DATA, d);
    cmp(d, 8'hC5);
    wr_reg(OFS_PIN_IN, 8'hFF);
    rd_reg(OFS_PIN_IN, d);
    cmp(d, 8'hC3);
    rd_reg(OFS_DIR, d);
    cmp(d, 8'h0F);
    rd_reg(8'h36, d);
    cmp(d, 8'h00);
  endtask
  task automatic t_drive_pull;
    ext_en <= 8'h00;
    @(posedge clk) an <= 8'h01;
    wr_reg(OFS_DIR, 8'hF0);
    wr_reg(OFS_DRIVE, 8'hFF);
    wr_reg(OFS_PULL_EN, 8'hFF);
    wr_reg(OFS_PULL_POL, 8'h05);
    cmp(drv, 8'hF0);
    cmp(pu, 8'h0A);
    cmp(pd, 8'h04);
    // new pull levels need two edges through the synchroniser
    repeat (2) @(posedge clk);
    rd_reg(OFS_PIN_IN, d);
    cmp(d & 8'h0E, 8'h0A);
  endtask
  task automatic t_periph;
    @(posedge clk) {pc, poe, po} <= {8'h0F, 8'h03, 8'h01};
    @(posedge clk) #1;
    cmp(oe, 8'hF3);
    cmp(pout & 8'h03, 8'h01);
    cmp(pu | pd, 8'h0C);
    cmp(drv, 8'hF3);
  endtask
  task automatic t_mid_reset;
    // pull enable is all ones here, so the reset check below can trip
    @(posedge clk) {pc, poe, po, rst_n} <= {24'h000000, 1'b0};
    repeat (2) @(posedge clk);
    rst_n <= 1;
    t_reset();
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    t_reset();
    t_read_back();
    t_drive_pull();
    t_periph();
    t_mid_reset();
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule
